// ---- analog_cmp_model.sv ----
module analog_cmp_model
    import cmp_pkg::*;
(
    input wire logic clk,
    input wire logic [cmp_pkg::NUM_CMP-1:0] level,
    output logic [cmp_pkg::NUM_CMP-1:0] compare_result
);
    timeunit 1ns;
    timeprecision 100ps;
    // registered so the result is synchronous to the core clock
    always_ff @(posedge clk) begin
        compare_result <= level;
    end
endmodule

// ---- cmp_config_bank.sv ----
// Behaviour
// (RULE_01) mode bit 5 enables rising-edge comparator interrupts.
// (RULE_02) mode bit 4 enables falling-edge comparator interrupts.
// (RULE_03) mode bits 7-6 read zero, writes to them ignored.
// (RULE_04) control bits 3-2 choose positive hysteresis, driven to comparator.
// (RULE_05) control bits 1-0 choose negative hysteresis, driven to comparator.
// (RULE_06) mode bits 1-0 are response time select, forwarded to comparator.
// (RULE_07) mode register at 0x89, instance chosen by page 1, 2 or 3.
// (RULE_08) edge flags set on output transitions, held until software clears.
// (RULE_09) interrupt request is OR of enabled rising and falling flags.
module cmp_config_bank
    import cmp_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input cmp_pkg::sfr_req_s SFR_REQ,
    output logic [7:0] SFR_RDATA,
    output logic SFR_HIT,
    input wire logic [cmp_pkg::NUM_CMP-1:0] COMPARE_RESULT,
    output cmp_pkg::analog_cfg_s [cmp_pkg::NUM_CMP-1:0] ANALOG_CFG,
    output logic [cmp_pkg::NUM_CMP-1:0] CMP_IRQ
);
    import cmp_pkg::*;

    logic [7:0] mode_r [NUM_CMP];
    logic [7:0] mode_nxt [NUM_CMP];
    logic [3:0] hyst_r [NUM_CMP];
    logic [3:0] hyst_nxt [NUM_CMP];
    logic [7:0] rdata_r, rdata_nxt;
    logic [NUM_CMP-1:0] rise_f, fall_f, clr_rise, clr_fall;
    logic [NUM_CMP-1:0] sel_mode, sel_ctrl;

    // page n+1 maps to instance n
    function automatic logic page_hit(input logic [7:0] page, input int idx);
        return page == PAGE_FIRST + 8'(idx); // RULE_07
    endfunction

    // unused mode bits never reach the flops
    function automatic logic [7:0] mode_keep(input logic [7:0] v);
        return v & MODE_RW_MASK; // RULE_03
    endfunction

    // upper two control bits belong to the rest of the unit and read zero here
    function automatic logic [7:0] ctrl_word(input logic rise, input logic fall,
        input logic [3:0] hyst);
        logic [7:0] w;
        w = CTRL_RESET;
        w[RIF_BIT] = rise;
        w[FIF_BIT] = fall;
        w[HYN_LSB +: 4] = hyst;
        return w;
    endfunction

    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            sel_mode[i] = page_hit(SFR_REQ.page, i) && SFR_REQ.addr == MODE_ADDR; // RULE_07
            sel_ctrl[i] = page_hit(SFR_REQ.page, i) && SFR_REQ.addr == CTRL_ADDR;
        end
    end

    always_comb begin
        rdata_nxt = rdata_r;
        for (int i = 0; i < NUM_CMP; i++) begin
            mode_nxt[i] = mode_r[i];
            hyst_nxt[i] = hyst_r[i];
            clr_rise[i] = 1'b0;
            clr_fall[i] = 1'b0;
            if (SFR_REQ.wr && sel_mode[i]) begin
                mode_nxt[i] = mode_keep(SFR_REQ.wdata); // RULE_03
            end
            if (SFR_REQ.wr && sel_ctrl[i]) begin
                hyst_nxt[i] = SFR_REQ.wdata[HYN_LSB +: 4]; // RULE_04 RULE_05
                // writing one to a flag leaves it; only zero clears
                clr_rise[i] = ~SFR_REQ.wdata[RIF_BIT]; // RULE_08
                clr_fall[i] = ~SFR_REQ.wdata[FIF_BIT]; // RULE_08
            end
            if (SFR_REQ.rd && sel_mode[i]) begin
                rdata_nxt = mode_keep(mode_r[i]); // RULE_03
            end
            if (SFR_REQ.rd && sel_ctrl[i]) begin
                rdata_nxt = ctrl_word(rise_f[i], fall_f[i], hyst_r[i]); // RULE_08
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                mode_r[i] <= MODE_RESET;
                hyst_r[i] <= CTRL_RESET[3:0];
            end
            rdata_r <= 8'h00;
        end else if (CE) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                mode_r[i] <= mode_nxt[i];
                hyst_r[i] <= hyst_nxt[i];
            end
            rdata_r <= rdata_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_cmp
            cmp_edge_unit u_edge (
                .clk(CLK),
                .resetn(RESETN),
                .ce(CE),
                .compare_result(COMPARE_RESULT[g]),
                .clr_rise(clr_rise[g]),
                .clr_fall(clr_fall[g]),
                .rising_edge_flag(rise_f[g]),
                .falling_edge_flag(fall_f[g])
            );
            assign ANALOG_CFG[g].positive_hysteresis_select = hyst_r[g][HYP_LSB +: 2]; // RULE_04
            assign ANALOG_CFG[g].negative_hysteresis_select = hyst_r[g][HYN_LSB +: 2]; // RULE_05
            assign ANALOG_CFG[g].response_time_select = mode_r[g][RT_LSB +: 2]; // RULE_06
            // enables gate the flags, flags stay visible either way
            assign CMP_IRQ[g] = (rise_f[g] & mode_r[g][RIE_BIT]) // RULE_01 RULE_09
                | (fall_f[g] & mode_r[g][FIE_BIT]); // RULE_02 RULE_09

            a_irq_rise: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_01
                rise_f[g] && mode_r[g][RIE_BIT] |-> CMP_IRQ[g])
                else $error("rising irq missing");

            a_irq_none: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_09
                !(rise_f[g] && mode_r[g][RIE_BIT]) && !(fall_f[g] && mode_r[g][FIE_BIT])
                |-> !CMP_IRQ[g])
                else $error("spurious comparator irq");

            a_irq_fall: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_02
                fall_f[g] && mode_r[g][FIE_BIT] |-> CMP_IRQ[g])
                else $error("falling irq missing");

            a_mode_write: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_07
                CE && SFR_REQ.wr && sel_mode[g]
                |=> mode_r[g] == ($past(SFR_REQ.wdata) & MODE_RW_MASK))
                else $error("mode write not stored");

            a_unused_zero: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_03
                mode_r[g][7:6] == 2'b00)
                else $error("unused mode bits set");

            a_rt_follow: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_06
                CE && SFR_REQ.wr && sel_mode[g]
                |=> ANALOG_CFG[g].response_time_select == $past(SFR_REQ.wdata[1:0]))
                else $error("response time not forwarded");

            a_hyst_write: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_04
                CE && SFR_REQ.wr && sel_ctrl[g]
                |=> ANALOG_CFG[g].positive_hysteresis_select == $past(SFR_REQ.wdata[3:2])
                && ANALOG_CFG[g].negative_hysteresis_select == $past(SFR_REQ.wdata[1:0]))
                else $error("hysteresis not forwarded"); // RULE_05

            a_mode_read: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_03
                CE && SFR_REQ.rd && sel_mode[g] |=> SFR_RDATA == mode_keep($past(mode_r[g])))
                else $error("mode read data wrong");

            a_ctrl_read: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_08
                CE && SFR_REQ.rd && sel_ctrl[g]
                |=> SFR_RDATA == ctrl_word($past(rise_f[g]), $past(fall_f[g]),
                $past(hyst_r[g])))
                else $error("control read data wrong");

            a_mode_keep: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_07
                CE && !(SFR_REQ.wr && sel_mode[g]) |=> $stable(mode_r[g]))
                else $error("mode changed without a write");

            a_hyst_keep: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_04
                CE && !(SFR_REQ.wr && sel_ctrl[g]) |=> $stable(hyst_r[g]))
                else $error("hysteresis changed without a write");

            // a low enable must freeze what the comparator and core see
            a_freeze_cfg: assert property (@(posedge CLK) disable iff (!RESETN)
                !CE |=> $stable(ANALOG_CFG[g]) && $stable(CMP_IRQ[g]))
                else $error("outputs moved while frozen");

            a_rise_clear: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_08
                CE && SFR_REQ.wr && sel_ctrl[g] && !SFR_REQ.wdata[RIF_BIT] && !COMPARE_RESULT[g]
                |=> !rise_f[g])
                else $error("rising flag not cleared");

            a_fall_clear: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_08
                CE && SFR_REQ.wr && sel_ctrl[g] && !SFR_REQ.wdata[FIF_BIT] && COMPARE_RESULT[g]
                |=> !fall_f[g])
                else $error("falling flag not cleared");

            a_rise_stays: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_08
                CE && SFR_REQ.wr && sel_ctrl[g] && SFR_REQ.wdata[RIF_BIT] && rise_f[g]
                |=> rise_f[g])
                else $error("rising flag lost on a one write");

            a_fall_stays: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_08
                CE && SFR_REQ.wr && sel_ctrl[g] && SFR_REQ.wdata[FIF_BIT] && fall_f[g]
                |=> fall_f[g])
                else $error("falling flag lost on a one write");
        end
    endgenerate

    assign SFR_RDATA = rdata_r;
    assign SFR_HIT = (|sel_mode) | (|sel_ctrl);

    a_freeze_rdata: assert property (@(posedge CLK) disable iff (!RESETN)
        !CE |=> $stable(SFR_RDATA))
        else $error("read data moved while frozen");

    a_rdata_hold: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_07
        CE && !(SFR_REQ.rd && SFR_HIT) |=> $stable(SFR_RDATA))
        else $error("read data changed without a hit");

    a_hit_decode: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_07
        SFR_HIT == ((SFR_REQ.addr == MODE_ADDR || SFR_REQ.addr == CTRL_ADDR)
        && SFR_REQ.page >= PAGE_FIRST && SFR_REQ.page < PAGE_FIRST + 8'(NUM_CMP)))
        else $error("register select decode wrong");
endmodule

// ---- cmp_edge_unit.sv ----
module cmp_edge_unit
    import cmp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic compare_result,
    input wire logic clr_rise,
    input wire logic clr_fall,
    output logic rising_edge_flag,
    output logic falling_edge_flag
);
    logic prev_r, prev_nxt, rise_r, rise_nxt, fall_r, fall_nxt;

    always_comb begin
        prev_nxt = compare_result;
        // set beats clear so an edge in the clear cycle is kept
        rise_nxt = (rise_r & ~clr_rise) | (compare_result & ~prev_r); // RULE_08
        fall_nxt = (fall_r & ~clr_fall) | (~compare_result & prev_r); // RULE_08
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_r <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else if (ce) begin
            prev_r <= prev_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign rising_edge_flag = rise_r;
    assign falling_edge_flag = fall_r;

    a_rise_sets: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
        ce && compare_result && !prev_r |=> rise_r)
        else $error("rising edge did not set flag");
    a_fall_holds: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
        ce && fall_r && !clr_fall |=> fall_r)
        else $error("falling flag dropped without clear");
    a_fall_sets: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
        ce && !compare_result && prev_r |=> fall_r)
        else $error("falling edge did not set flag");
    a_rise_holds: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
        ce && rise_r && !clr_rise |=> rise_r)
        else $error("rising flag dropped without clear");
    a_freeze_flags: assert property (@(posedge clk) disable iff (!resetn)
        !ce |=> $stable(rise_r) && $stable(fall_r) && $stable(prev_r))
        else $error("edge state moved while frozen");
endmodule

// ---- cmp_pkg.sv ----
package cmp_pkg;
    localparam int NUM_CMP = 3;
    localparam logic [7:0] MODE_ADDR = 8'h89;
    localparam logic [7:0] CTRL_ADDR = 8'h88;
    localparam logic [7:0] PAGE_FIRST = 8'h01;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // mode field positions
    localparam int RIE_BIT = 5;
    localparam int FIE_BIT = 4;
    localparam int RT_LSB = 0;
    // control field positions
    localparam int RIF_BIT = 5;
    localparam int FIF_BIT = 4;
    localparam int HYP_LSB = 2;
    localparam int HYN_LSB = 0;
    localparam logic [7:0] MODE_RW_MASK = 8'h33;
    localparam logic [7:0] CTRL_LOW_MASK = 8'h0F;

    typedef struct packed {
        logic [1:0] positive_hysteresis_select;
        logic [1:0] negative_hysteresis_select;
        logic [1:0] response_time_select;
    } analog_cfg_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;
endpackage

// ---- comparator_edge_irq_config_test.sv ----
module comparator_edge_irq_config_test;
    timeunit 1ns;
    timeprecision 100ps;
    import cmp_pkg::*;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic CE = 1'b1;
    sfr_req_s req = '0;
    logic [7:0] rdata;
    logic hit;
    logic h;
    logic lv;
    logic [NUM_CMP-1:0] level = '0;
    logic [NUM_CMP-1:0] cres;
    analog_cfg_s [NUM_CMP-1:0] cfg;
    logic [NUM_CMP-1:0] irq;
    int fails = 0;
    int comparisons = 0;
    int seed = 63641;
    logic [7:0] mode_m [NUM_CMP];
    logic [3:0] hyst_m [NUM_CMP];
    logic [1:0] flag_m [NUM_CMP];
    logic [7:0] d;
    logic [7:0] pg;
    always #5 CLK = ~CLK;
    cmp_config_bank uut (.CLK(CLK), .RESETN(RESETN), .CE(CE), .SFR_REQ(req), .SFR_RDATA(rdata),
        .SFR_HIT(hit), .COMPARE_RESULT(cres), .ANALOG_CFG(cfg), .CMP_IRQ(irq));
    analog_cmp_model far (.clk(CLK), .level(level), .compare_result(cres));
    function automatic logic [7:0] ctrl_exp(int i);
        return {2'h0, flag_m[i], hyst_m[i]};
    endfunction
    function automatic logic irq_exp(int i);
        return (flag_m[i][1] & mode_m[i][RIE_BIT]) | (flag_m[i][0] & mode_m[i][FIE_BIT]);
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_cfg(input analog_cfg_s got, input analog_cfg_s exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held one full cycle, taken at the second edge
    task automatic access(input logic w, input logic [7:0] p, input logic [7:0] a,
        input logic [7:0] wd, output logic ht);
        @(posedge CLK);
        req <= '{w, !w, p, a, wd};
        #1 ht = hit;
        @(posedge CLK);
        req <= '0;
        #1;
    endtask
    task automatic report_and_stop;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #500000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge CLK);
        RESETN <= 1'b1;
        for (int i = 0; i < NUM_CMP; i++) begin
            mode_m[i] = MODE_RESET;
            hyst_m[i] = 4'h0;
            flag_m[i] = 2'h0;
            access(1'b0, 8'(PAGE_FIRST + i), MODE_ADDR, 8'h00, h);
            check(rdata, MODE_RESET);
            access(1'b0, 8'(PAGE_FIRST + i), CTRL_ADDR, 8'h00, h);
            check(rdata, CTRL_RESET);
        end
        for (int n = 0; n < 60; n++) begin
            int i;
            i = $unsigned($random(seed)) % NUM_CMP;
            pg = 8'(PAGE_FIRST + i);
            // corner first: all ones into the unused bits
            d = (n == 0) ? 8'hFF : 8'($random(seed));
            access(1'b1, pg, MODE_ADDR, d, h);
            mode_m[i] = d & MODE_RW_MASK;
            d = 8'($random(seed));
            access(1'b1, pg, CTRL_ADDR, d, h);
            hyst_m[i] = d[3:0];
            flag_m[i] = flag_m[i] & d[5:4];
            lv = 1'($random(seed));
            if (lv != level[i]) flag_m[i] = flag_m[i] | (lv ? 2'h2 : 2'h1);
            @(posedge CLK);
            level[i] <= lv;
            repeat (3) @(posedge CLK);
            #1;
            for (int k = 0; k < NUM_CMP; k++) begin
                check_flag(irq[k], irq_exp(k));
                check_cfg(cfg[k], {hyst_m[k], mode_m[k][1:0]});
            end
            access(1'b0, pg, MODE_ADDR, 8'h00, h);
            check(rdata, mode_m[i]);
            access(1'b0, pg, CTRL_ADDR, 8'h00, h);
            check(rdata, ctrl_exp(i));
        end
        // frozen core: a write under a low enable must not land
        @(posedge CLK);
        CE <= 1'b0;
        access(1'b1, PAGE_FIRST, MODE_ADDR, ~mode_m[0], h);
        @(posedge CLK);
        CE <= 1'b1;
        #1;
        check_cfg(cfg[0], {hyst_m[0], mode_m[0][1:0]});
        access(1'b0, PAGE_FIRST, MODE_ADDR, 8'h00, h);
        check_flag(h, 1'b1);
        check(rdata, mode_m[0]);
        for (int k = 0; k < 3; k++) begin
            access(1'b0, k == 2 ? PAGE_FIRST : 8'(k * 4), k == 2 ? 8'h8A : MODE_ADDR, 8'h00, h);
            check_flag(h, 1'b0);
            check(rdata, mode_m[0]);
        end
        report_and_stop();
    end
endmodule
